/* File: hdl/serial_master_unit_evt_cfg.svh */
// Purpose: Constants for the serial master event and interrupt registers
// Assumes: APB byte addresses, 32-bit data
// Notes:   Offsets are byte addresses within the peripheral
`ifndef SERIAL_MASTER_UNIT_EVT_CFG_SVH
`define SERIAL_MASTER_UNIT_EVT_CFG_SVH

`define AW            12
`define DW            32
`define NEV           5
`define OFF_STOPPED   12'h104
`define OFF_RX_DONE   12'h110
`define OFF_END       12'h118
`define OFF_TX_DONE   12'h120
`define OFF_STARTED   12'h14C
`define OFF_EVENT_TASK_SHORTCUTS    12'h200
`define OFF_IRQ_SET   12'h304
`define OFF_IRQ_CLR   12'h308
`define OFF_IRQ_STAT  12'h30C
`define BIT_FLAG      0
`define BIT_END_START 0
`define BIT_STOPPED   0
`define BIT_RX_DONE   1
`define BIT_END       2
`define BIT_TX_DONE   3
`define BIT_STARTED   4
`define RST_FLAG      1'b0
`define RST_SHORT     1'b0
`define RST_EVT       5'h00
`define RST_WORD      32'h0000_0000

`endif

/* File: hdl/serial_master_unit_evt_pkg.sv */
// Purpose: Types for the serial master event and interrupt registers
// Assumes: Field order matches the enable register bit layout
// Notes:   Packed order puts the stopped event in bit 0
package serial_master_unit_evt_pkg;

  typedef struct packed {
    logic started;
    logic tx_done;
    logic end_both;
    logic rx_done;
    logic stopped;
  } evt_vec_s;

  typedef enum logic [1:0] {
    TRK_NONE,
    TRK_RX_SEEN,
    TRK_TX_SEEN
  } end_trk_e;

endpackage

/* File: hdl/event_flag.sv */
// Purpose: One sticky event flag
// Assumes: Set and clear are single-cycle terms
// Notes:   Set wins over clear in the same cycle
`include "serial_master_unit_evt_cfg.svh"

module event_flag (
  input  wire logic sys_clk_i, // System clock
  input  wire logic rst_n_i,   // Async reset, active low
  input  wire logic set_i,     // Hardware event
  input  wire logic clr_i,     // Software clear
  output logic      flag_o     // Sticky flag
);

  logic flag_q;
  logic flag_d;

  // A late clear must not swallow a fresh event
  assign flag_d = set_i | (flag_q & ~clr_i);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_q <= `RST_FLAG;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule

/* File: hdl/spi_master_event_irq_regs.sv */
// Purpose: Event flags, restart shortcut and interrupt enables of the serial master
// Assumes: Core event inputs are one-cycle pulses on sys_clk_i
// Notes:   APB slave with no wait states
//          Flag words: stopped 0x104, rx done 0x110, end 0x118,
//          tx done 0x120, started 0x14C; bit 0 only, write 1 sets, write 0 clears
//          Shortcut 0x200 bit 0 restarts the transfer on the end event
//          Enable set 0x304 and enable clear 0x308 both read the enables
//          Status 0x30C reads all five flags; write 1 clears a flag
//          Bit order of enables and status: stopped, rx done, end, tx done, started
//          A flag event in the cycle of its clear keeps the flag set
//          Irq output lags the flag and enable by one cycle
//          Unmapped offsets answer with an error, read 0 and drop writes
//
// The implementer's own choice: the APB slave port.
`include "serial_master_unit_evt_cfg.svh"

module spi_master_event_irq_regs (
  input  wire logic            sys_clk_i,      // System clock, 100 MHz
  input  wire logic            rst_n_i,        // Async reset, active low
  input  wire logic            psel,           // APB select
  input  wire logic            penable,        // APB enable
  input  wire logic            pwrite,         // APB direction
  input  wire logic [`AW-1:0]  paddr,          // APB byte address
  input  wire logic [`DW-1:0]  pwdata,         // APB write data
  output logic [`DW-1:0]       prdata,         // APB read data
  output logic                 pready,         // APB ready
  output logic                 pslverr,        // APB error
  input  wire logic            stop_task_i,    // Stop task issued
  input  wire logic            halted_i,       // Core has halted
  input  wire logic            rx_end_i,       // Receive buffer end reached
  input  wire logic            tx_end_i,       // Last transmit byte consumed
  input  wire logic            begin_i,        // Transaction has begun
  output logic                 start_task_o,   // Start task from shortcut
  output serial_master_unit_evt_pkg::evt_vec_s event_o,      // Event pulses
  output logic                 irq_o           // Interrupt request
);

  // Bus decode
  wire logic setup_ph;
  wire logic access_ph;
  wire logic wr_acc;
  wire logic hit_stopped;
  wire logic hit_rx_done;
  wire logic hit_end;
  wire logic hit_tx_done;
  wire logic hit_started;
  wire logic hit_event_task_shortcuts;
  wire logic hit_irq_set;
  wire logic hit_irq_clr;
  wire logic hit_irq_stat;
  wire logic hit_any;
  wire logic rd_setup;
  wire logic wr_event_task_shortcuts;
  wire logic wr_stat;
  wire logic bad_acc;

  // Address compare only; psel qualifies every use below
  assign setup_ph     = psel & ~penable;
  assign access_ph    = psel & penable;
  assign wr_acc       = access_ph & pwrite;
  assign hit_stopped  = (paddr == `OFF_STOPPED);
  assign hit_rx_done  = (paddr == `OFF_RX_DONE);
  assign hit_end      = (paddr == `OFF_END);
  assign hit_tx_done  = (paddr == `OFF_TX_DONE);
  assign hit_started  = (paddr == `OFF_STARTED);
  assign hit_event_task_shortcuts   = (paddr == `OFF_EVENT_TASK_SHORTCUTS);
  assign hit_irq_set  = (paddr == `OFF_IRQ_SET);
  assign hit_irq_clr  = (paddr == `OFF_IRQ_CLR);
  assign hit_irq_stat = (paddr == `OFF_IRQ_STAT);
  assign hit_any      = hit_stopped | hit_rx_done | hit_end
                      | hit_tx_done | hit_started | hit_event_task_shortcuts
                      | hit_irq_set | hit_irq_clr | hit_irq_stat;
  assign rd_setup     = setup_ph & ~pwrite;
  assign wr_event_task_shortcuts    = wr_acc & hit_event_task_shortcuts;
  assign wr_stat      = wr_acc & hit_irq_stat;
  assign bad_acc      = access_ph & ~hit_any;

  // Zero wait states keep the master simple
  assign pready  = 1'b1;
  assign pslverr = bad_acc;

  // Event sources
  serial_master_unit_evt_pkg::end_trk_e trk_q;
  serial_master_unit_evt_pkg::end_trk_e trk_d;
  logic                   stop_pend_q;
  logic                   stop_pend_d;
  wire logic              ev_stopped;
  wire logic              ev_end;
  wire logic              ev_tx_done;
  wire logic              ev_started;
  wire logic              ev_rx_done;
  wire logic              both_end;
  wire logic              rx_only;
  wire logic              tx_only;
  wire logic              rx_half;
  wire logic              tx_half;
  wire logic              trk_forget;
  wire logic              stop_seen;

  assign both_end   = rx_end_i & tx_end_i;
  assign rx_only    = rx_end_i & ~tx_end_i;
  assign tx_only    = tx_end_i & ~rx_end_i;
  assign rx_half    = (trk_q == serial_master_unit_evt_pkg::TRK_RX_SEEN);
  assign tx_half    = (trk_q == serial_master_unit_evt_pkg::TRK_TX_SEEN);
  assign trk_forget = begin_i & ~rx_end_i & ~tx_end_i;
  assign stop_seen  = stop_pend_q | stop_task_i;

  assign ev_stopped = halted_i & stop_seen;
  assign ev_rx_done = rx_end_i;
  assign ev_tx_done = tx_end_i;
  assign ev_started = begin_i;

  // Both ends in one cycle, or the second after the first
  assign ev_end = both_end
                | (rx_end_i & tx_half)
                | (tx_end_i & rx_half);

  // Remembers which buffer end came first in a transaction
  always_comb begin
    trk_d = trk_q;
    case (trk_q)
      serial_master_unit_evt_pkg::TRK_NONE: begin
        if (rx_only) begin
          trk_d = serial_master_unit_evt_pkg::TRK_RX_SEEN;
        end else if (tx_only) begin
          trk_d = serial_master_unit_evt_pkg::TRK_TX_SEEN;
        end
      end
      serial_master_unit_evt_pkg::TRK_RX_SEEN: begin
        if (tx_end_i) begin
          trk_d = serial_master_unit_evt_pkg::TRK_NONE;
        end
      end
      serial_master_unit_evt_pkg::TRK_TX_SEEN: begin
        if (rx_end_i) begin
          trk_d = serial_master_unit_evt_pkg::TRK_NONE;
        end
      end
      default: begin
        trk_d = serial_master_unit_evt_pkg::TRK_NONE;
      end
    endcase
    // A new transaction forgets half-finished ends
    if (trk_forget) begin
      trk_d = serial_master_unit_evt_pkg::TRK_NONE;
    end
  end

  // A stop in the halt cycle is consumed by that halt
  always_comb begin
    stop_pend_d = stop_pend_q;
    if (halted_i) begin
      stop_pend_d = 1'b0;
    end else if (stop_task_i) begin
      stop_pend_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trk_q       <= serial_master_unit_evt_pkg::TRK_NONE;
      stop_pend_q <= 1'b0;
    end else begin
      trk_q       <= trk_d;
      stop_pend_q <= stop_pend_d;
    end
  end

  // Sticky flags
  wire logic [`NEV-1:0] ev_vec;
  wire logic [`NEV-1:0] hit_flag;
  wire logic [`NEV-1:0] clr_flag;
  wire logic [`NEV-1:0] set_flag;
  wire logic [`NEV-1:0] wr_one;
  wire logic [`NEV-1:0] wr_zero;
  logic      [`NEV-1:0] flags;

  assign ev_vec[`BIT_STOPPED]   = ev_stopped;
  assign ev_vec[`BIT_RX_DONE]   = ev_rx_done;
  assign ev_vec[`BIT_END]       = ev_end;
  assign ev_vec[`BIT_TX_DONE]   = ev_tx_done;
  assign ev_vec[`BIT_STARTED]   = ev_started;

  assign hit_flag[`BIT_STOPPED] = hit_stopped;
  assign hit_flag[`BIT_RX_DONE] = hit_rx_done;
  assign hit_flag[`BIT_END]     = hit_end;
  assign hit_flag[`BIT_TX_DONE] = hit_tx_done;
  assign hit_flag[`BIT_STARTED] = hit_started;

  genvar gi;
  generate
    for (gi = 0; gi < `NEV; gi = gi + 1) begin : g_flag
      // Flag word: write 1 sets, write 0 clears; status word: write 1 clears
      assign wr_one[gi]   = wr_acc & hit_flag[gi] & pwdata[`BIT_FLAG];
      assign wr_zero[gi]  = wr_acc & hit_flag[gi] & ~pwdata[`BIT_FLAG];
      assign set_flag[gi] = ev_vec[gi] | wr_one[gi];
      assign clr_flag[gi] = wr_zero[gi] | (wr_stat & pwdata[gi]);
      event_flag u_flag (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .set_i     (set_flag[gi]),
        .clr_i     (clr_flag[gi]),
        .flag_o    (flags[gi])
      );
    end
  endgenerate

  // Shortcut and interrupt enables
  logic            end_start_q;
  logic            end_start_d;
  logic [`NEV-1:0] irq_en_q;
  logic [`NEV-1:0] irq_en_d;
  wire logic       wr_en_set;
  wire logic       wr_en_clr;

  assign wr_en_set = wr_acc & hit_irq_set;
  assign wr_en_clr = wr_acc & hit_irq_clr;

  always_comb begin
    end_start_d = end_start_q;
    if (wr_event_task_shortcuts) begin
      end_start_d = pwdata[`BIT_END_START];
    end
  end

  always_comb begin
    irq_en_d = irq_en_q;
    if (wr_en_set) begin
      irq_en_d = irq_en_d | pwdata[`NEV-1:0];
    end
    if (wr_en_clr) begin
      irq_en_d = irq_en_d & ~pwdata[`NEV-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      end_start_q <= `RST_SHORT;
      irq_en_q    <= `RST_EVT;
    end else begin
      end_start_q <= end_start_d;
      irq_en_q    <= irq_en_d;
    end
  end

  // Restart rides on the same cycle as the end event
  assign start_task_o = ev_end & end_start_q;

  // Event pulses to the rest of the master
  assign event_o.stopped  = ev_stopped;
  assign event_o.rx_done  = ev_rx_done;
  assign event_o.end_both = ev_end;
  assign event_o.tx_done  = ev_tx_done;
  assign event_o.started  = ev_started;

  // Interrupt output, registered to avoid glitches
  logic                 irq_q;
  wire logic            irq_d;
  wire logic [`NEV-1:0] irq_pend;

  // Only an unmasked flag may raise the request
  assign irq_pend = flags & irq_en_q;
  assign irq_d    = |irq_pend;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq_o = irq_q;

  // Read mux
  wire logic [`DW-1:0] rd_flag;
  wire logic [`DW-1:0] rd_en;
  wire logic [`DW-1:0] rd_stat;
  wire logic [`DW-1:0] rd_short;
  wire logic [`DW-1:0] rd_word;
  logic      [`DW-1:0] prdata_q;
  logic      [`DW-1:0] prdata_d;
  wire logic [`NEV-1:0] flag_sel;
  wire logic            sel_en;
  wire logic            sel_stat;
  wire logic            sel_short;
  wire logic            sel_flag;

  assign rd_en    = {{(`DW-`NEV){1'b0}}, irq_en_q};
  assign rd_stat  = {{(`DW-`NEV){1'b0}}, flags};
  assign rd_short = {{(`DW-1){1'b0}}, end_start_q};
  assign flag_sel = flags & hit_flag;
  assign rd_flag  = {{(`DW-1){1'b0}}, |flag_sel};

  // And-or mux: the address hits never overlap
  assign sel_en    = hit_irq_set | hit_irq_clr;
  assign sel_stat  = hit_irq_stat;
  assign sel_short = hit_event_task_shortcuts;
  assign sel_flag  = |hit_flag;
  assign rd_word = ({`DW{sel_en}}    & rd_en)
                 | ({`DW{sel_stat}}  & rd_stat)
                 | ({`DW{sel_short}} & rd_short)
                 | ({`DW{sel_flag}}  & rd_flag);

  // Sampled in setup so the data stands through access
  always_comb begin
    prdata_d = prdata_q;
    if (rd_setup) begin
      prdata_d = hit_any ? rd_word : `RST_WORD;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_q <= `RST_WORD;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

endmodule

/* File: dv/serial_master_unit_evt_sva.sv */
// Purpose: Port checks for the event and interrupt registers
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Sees only the top module ports
`include "serial_master_unit_evt_cfg.svh"

module serial_master_unit_evt_sva (
  input wire logic                   sys_clk_i,    // Clock
  input wire logic                   rst_n_i,      // Reset
  input wire logic                   psel,         // APB select
  input wire logic                   penable,      // APB enable
  input wire logic                   pwrite,       // APB direction
  input wire logic [`AW-1:0]         paddr,        // APB address
  input wire logic [`DW-1:0]         prdata,       // APB read data
  input wire logic                   pready,       // APB ready
  input wire logic                   pslverr,      // APB error
  input wire logic                   stop_task_i,  // Stop task
  input wire logic                   halted_i,     // Halted
  input wire logic                   rx_end_i,     // Receive end
  input wire logic                   tx_end_i,     // Transmit end
  input wire logic                   begin_i,      // Transaction begin
  input wire logic                   start_task_o, // Restart
  input wire serial_master_unit_evt_pkg::evt_vec_s event_o       // Event pulses
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Begin clears half-seen tracking, so keep it out of the window
  sequence s_split_end;
    rx_end_i && !tx_end_i && !begin_i ##1 !tx_end_i && !begin_i ##1 tx_end_i && !begin_i;
  endsequence
  sequence s_stop_halt;
    stop_task_i && !halted_i ##1 !halted_i ##1 halted_i;
  endsequence

  property p_tx_evt; tx_end_i |-> event_o.tx_done; endproperty
  property p_start_evt; begin_i |-> event_o.started; endproperty
  property p_split_end; s_split_end |-> event_o.end_both; endproperty
  property p_end_cause; event_o.end_both |-> rx_end_i || tx_end_i; endproperty
  property p_short; start_task_o |-> event_o.end_both; endproperty
  property p_stop; s_stop_halt |-> event_o.stopped; endproperty
  property p_stop_cause; event_o.stopped |-> halted_i; endproperty
  property p_enable_ok; psel && penable && paddr == `OFF_IRQ_SET |-> pready && !pslverr; endproperty
  property p_rd_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty

  a_tx_evt: assert property (p_tx_evt) else $error("transmit event missing");
  a_start_evt: assert property (p_start_evt) else $error("started event missing");
  a_split_end: assert property (p_split_end) else $error("end event missing");
  a_end_cause: assert property (p_end_cause) else $error("end event without buffer end");
  a_short: assert property (p_short) else $error("restart without end event");
  a_stop: assert property (p_stop) else $error("stopped event missing");
  a_stop_cause: assert property (p_stop_cause) else $error("stopped event without halt");
  a_enable_ok: assert property (p_enable_ok) else $error("enable access refused");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule

bind spi_master_event_irq_regs serial_master_unit_evt_sva serial_master_unit_evt_sva_i (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_task_i(stop_task_i),
  .halted_i(halted_i), .rx_end_i(rx_end_i), .tx_end_i(tx_end_i), .begin_i(begin_i),
  .start_task_o(start_task_o), .event_o(event_o)
);

/* File: dv/spi_master_event_irq_regs_tb.sv */
// Purpose: Self-checking bench for the event and interrupt registers
// Assumes: Event inputs pulse for one cycle
// Notes:   Table of register accesses, then hand tests
`include "serial_master_unit_evt_cfg.svh"

module spi_master_event_irq_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [`AW-1:0] a; logic w; logic [`DW-1:0] d;} row_s;
  logic                   sys_clk_i = 1'b0;
  logic                   rst_n_i   = 1'b0;
  logic                   psel      = 1'b0;
  logic                   penable   = 1'b0;
  logic                   pwrite    = 1'b0;
  logic [`AW-1:0]         paddr     = 12'h000;
  logic [`DW-1:0]         pwdata    = 32'h0;
  logic [4:0]             stim      = 5'h00;
  logic [`DW-1:0]         prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   start_task;
  logic                   irq;
  serial_master_unit_evt_pkg::evt_vec_s evo;
  logic [5:0]             got;
  logic [`DW-1:0]         rd;
  logic                   rd_err;
  int                     err_total   = 0;
  int                     checks_done = 0;
  // Reads carry the expected word in d, writes the data to write
  row_s rows [15] = '{'{12'h120, 1'b0, 32'h0}, '{12'h14C, 1'b0, 32'h0}, '{12'h200, 1'b0, 32'h0},
    '{12'h304, 1'b0, 32'h0}, '{12'h308, 1'b0, 32'h0}, '{12'h304, 1'b1, 32'h15}, '{12'h308, 1'b0, 32'h15},
    '{12'h304, 1'b1, 32'h0A}, '{12'h304, 1'b0, 32'h1F}, '{12'h308, 1'b1, 32'h05}, '{12'h304, 1'b0, 32'h1A},
    '{12'h308, 1'b1, 32'h0}, '{12'h308, 1'b0, 32'h1A}, '{12'h308, 1'b1, 32'h1A}, '{12'h304, 1'b0, 32'h0}};

  spi_master_event_irq_regs spi_master_event_irq_regs_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_task_i(stim[0]), .halted_i(stim[1]), .rx_end_i(stim[2]), .tx_end_i(stim[3]), .begin_i(stim[4]),
    .start_task_o(start_task), .event_o(evo), .irq_o(irq));

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input logic [`DW-1:0] val, input logic [`DW-1:0] exp);
    checks_done++;
    if (val !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, val, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [`AW-1:0] a, input logic [`DW-1:0] d);
    int n;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      end_sim();
    end else begin
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Outputs are combinational, so look 1 ns after the launching edge
  task automatic pulse(input logic [4:0] v);
    @(posedge sys_clk_i);
    stim <= v;
    #1;
    got = {start_task, evo};
    @(posedge sys_clk_i);
    stim <= 5'h00;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].d);
    end
    $display("Register table done");
    pulse(5'h08);
    chk(32'(got), 32'h08);
    apb(1'b0, `OFF_TX_DONE, 32'h0);
    chk(rd, 32'h1);
    pulse(5'h10);
    apb(1'b0, `OFF_STARTED, 32'h0);
    chk(rd, 32'h1);
    $display("Event flags done");
    apb(1'b1, `OFF_EVENT_TASK_SHORTCUTS, 32'h1);
    apb(1'b1, `OFF_IRQ_SET, 32'h4);
    pulse(5'h04);
    chk(32'(got), 32'h02);
    pulse(5'h08);
    chk(32'(got), 32'h2C);
    repeat (2) @(posedge sys_clk_i);
    chk(32'(irq), 32'h1);
    apb(1'b1, `OFF_END, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    chk(32'(irq), 32'h0);
    apb(1'b1, `OFF_EVENT_TASK_SHORTCUTS, 32'h0);
    pulse(5'h0C);
    chk(32'(got), 32'h0E);
    pulse(5'h08);
    chk(32'(got), 32'h08);
    $display("End event and shortcut done");
    pulse(5'h01);
    pulse(5'h02);
    chk(32'(got), 32'h01);
    apb(1'b0, `OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h1F);
    apb(1'b1, `OFF_IRQ_STAT, 32'h15);
    apb(1'b0, `OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0A);
    // Transmit end lands on the same edge as its status clear
    fork
      apb(1'b1, `OFF_IRQ_STAT, 32'h08);
      begin
        repeat (2) @(posedge sys_clk_i);
        stim <= 5'h08;
        @(posedge sys_clk_i);
        stim <= 5'h00;
      end
    join
    apb(1'b0, `OFF_TX_DONE, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h500, 32'h0);
    chk(rd, 32'h0);
    chk(32'(rd_err), 32'h1);
    apb(1'b1, `OFF_IRQ_SET, 32'h1F);
    repeat (2) @(posedge sys_clk_i);
    chk(32'(irq), 32'h1);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, `OFF_IRQ_CLR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    $display("Stop, unmapped and reset done");
    end_sim();
  end
endmodule
